// file: ctm_consts.vh
`ifndef CTM_CONSTS_VH
`define CTM_CONSTS_VH
// Coprocessor register groups
`define CTM_CRN_ID 4'h0
`define CTM_CRN_CACHE 4'h7
`define CTM_CRN_TLB 4'h8
`define CTM_OP1_MAINT 3'h0
`define CTM_CRM_FEAT 4'h1
`define CTM_CRM_ISAR 4'h2
`define CTM_CRM_PAR 4'h4
`define CTM_CRM_PROBE 4'h8
`define CTM_CRM_IC_IS 4'h1
`define CTM_CRM_IC 4'h5
`define CTM_CRM_DC_INV 4'h6
`define CTM_CRM_DC_CLN 4'hA
`define CTM_CRM_DC_CLNU 4'hB
`define CTM_CRM_DC_CI 4'hE
`define CTM_CRM_TLB_IS 4'h3
`define CTM_CRM_TLB_A 4'h5
`define CTM_CRM_TLB_B 4'h6
`define CTM_CRM_TLB 4'h7
// Selector values
`define CTM_OP2_ALL 3'h0
`define CTM_OP2_VA 3'h1
`define CTM_OP2_SW 3'h2
`define CTM_OP2_AALL 3'h3
`define CTM_OP2_BAR 3'h4
`define CTM_OP2_DMB 3'h5
`define CTM_OP2_BP 3'h6
`define CTM_OP2_BPVA 3'h7
`define CTM_OP2_FEAT_RSVD 3'h3
`define CTM_OP2_ISAR_LAST 3'h4
`define CTM_OP2_NS 2
// Operand fields
`define CTM_WAY_HI 31
`define CTM_WAY_LO 30
`define CTM_SET_HI_MAX 13
`define CTM_SET_LO 5
`define CTM_SET_W 9
`define CTM_SET_ALL 9'h1FF
`define CTM_PAGE_LO 12
`define CTM_ADDRESS_SPACE_ID_HI 7
// Cache request kinds
`define CTM_K_NONE 3'h0
`define CTM_K_INV 3'h1
`define CTM_K_CLEAN 3'h2
`define CTM_K_CLNINV 3'h3
`define CTM_K_IC_VA 3'h4
`define CTM_K_IC_ALL 3'h5
`define CTM_K_BP 3'h6
// Cache and TLB geometry
`define CTM_CACHE_KB 32
`define CTM_TLB_N 8
`define CTM_TLB_LAST 3'h7
// Physical address result
`define CTM_PAR_FAULT 32'h00000001
`define CTM_PAR_RESET 32'h00000000
`define CTM_PAR_PAGE_MASK 32'hFFFFF000
// Identification values
`define CTM_PFR0 32'h00001231
`define CTM_PFR1 32'h00000011
`define CTM_DFR0 32'h02010444
`define CTM_MMFR0 32'h00100003
`define CTM_MMFR1 32'h40000000
`define CTM_MMFR2 32'h01230000
`define CTM_MMFR3 32'h00102211
`define CTM_ISAR0 32'h00101111
`define CTM_ISAR1 32'h13112111
`define CTM_ISAR2 32'h00000000
`define CTM_ISAR3 32'h00000000
`define CTM_ISAR4 32'h00000000
`define CTM_ZERO 32'h00000000
`endif

// file: ctm_tlb_entry.v
`timescale 1ns/10ps
`default_nettype none
`include "ctm_consts.vh"
module ctm_tlb_entry (
   input wire clk_sys,
   input wire rst,
   input wire fill_we,
   input wire [19:0] fill_vpn,
   input wire [19:0] fill_ppn,
   input wire [7:0] fill_address_space_id,
   input wire fill_glob,
   input wire fill_ns,
   input wire [2:0] fill_perm,
   input wire kill,
   input wire [19:0] look_vpn,
   input wire look_ns,
   output wire vmatch,
   output wire glob,
   output wire [7:0] address_space_id,
   output wire [19:0] ppn,
   output wire [2:0] perm
);
   reg valid_q;
   reg [19:0] vpn_q;
   reg [19:0] ppn_q;
   reg [7:0] address_space_id_q;
   reg glob_q;
   reg ns_q;
   reg [2:0] perm_q;

   // A fill in the same cycle as a kill installs the new entry
   always @(posedge clk_sys) begin
      if (rst) begin
         valid_q <= 1'b0;
         vpn_q <= 20'h00000;
         ppn_q <= 20'h00000;
         address_space_id_q <= 8'h00;
         glob_q <= 1'b0;
         ns_q <= 1'b0;
         perm_q <= 3'h0;
      end else if (fill_we) begin
         valid_q <= 1'b1;
         vpn_q <= fill_vpn;
         ppn_q <= fill_ppn;
         address_space_id_q <= fill_address_space_id;
         glob_q <= fill_glob;
         ns_q <= fill_ns;
         perm_q <= fill_perm;
      end else if (kill) begin
         valid_q <= 1'b0;
      end
   end

   assign vmatch = valid_q & (vpn_q == look_vpn) & (ns_q == look_ns);
   assign glob = glob_q;
   assign address_space_id = address_space_id_q;
   assign ppn = ppn_q;
   assign perm = perm_q;
endmodule // ctm_tlb_entry
`default_nettype wire

// file: ctm_id_rom.v
`timescale 1ns/10ps
`default_nettype none
`include "ctm_consts.vh"
module ctm_id_rom (
   input wire isar_sel,
   input wire [2:0] sel,
   output reg [31:0] data
);
   always @* begin
      data = `CTM_ZERO;
      if (isar_sel) begin
         case (sel)
            3'h0: data = `CTM_ISAR0;
            3'h1: data = `CTM_ISAR1;
            3'h2: data = `CTM_ISAR2;
            3'h3: data = `CTM_ISAR3;
            3'h4: data = `CTM_ISAR4;
            default: data = `CTM_ZERO;
         endcase
      end else begin
         case (sel)
            3'h0: data = `CTM_PFR0;
            3'h1: data = `CTM_PFR1;
            3'h2: data = `CTM_DFR0;
            3'h4: data = `CTM_MMFR0;
            3'h5: data = `CTM_MMFR1;
            3'h6: data = `CTM_MMFR2;
            3'h7: data = `CTM_MMFR3;
            default: data = `CTM_ZERO;
         endcase
      end
   end
endmodule // ctm_id_rom
`default_nettype wire

// file: ctm_maint.v
`timescale 1ns/10ps
`default_nettype none
`include "ctm_consts.vh"
module ctm_maint (
   input wire clk_sys,
   input wire rst,
   input wire cp_valid,
   output wire cp_ready,
   input wire cp_write,
   input wire [3:0] cp_crn,
   input wire [2:0] cp_op1,
   input wire [3:0] cp_crm,
   input wire [2:0] cp_op2,
   input wire [31:0] cp_wdata,
   input wire priv_mode,
   input wire secure_state,
   input wire [7:0] ctx_address_space_id,
   output reg rsp_valid_q,
   output reg rsp_undef_q,
   output reg [31:0] rsp_rdata_q,
   input wire tlb_fill_valid,
   input wire [19:0] tlb_fill_vpn,
   input wire [19:0] tlb_fill_ppn,
   input wire [7:0] tlb_fill_address_space_id,
   input wire tlb_fill_glob,
   input wire tlb_fill_ns,
   input wire [2:0] tlb_fill_perm,
   output wire tlb_stable,
   output reg cache_req_q,
   output reg [2:0] cache_kind_q,
   output reg cache_setway_q,
   output reg [1:0] cache_way_q,
   output reg [8:0] cache_set_q,
   output reg [26:0] cache_line_q
);
   localparam ST_IDLE = 2'h0;
   localparam ST_ICALL = 2'h1;
   localparam ST_ADDRESS_SPACE_ID = 2'h2;

   function integer ctm_s_of;
      input integer kb;
      begin
         case (kb)
            4: ctm_s_of = 5;
            8: ctm_s_of = 6;
            16: ctm_s_of = 7;
            32: ctm_s_of = 8;
            64: ctm_s_of = 9;
            default: ctm_s_of = 8;
         endcase
      end
   endfunction

   localparam integer SET_BITS = ctm_s_of(`CTM_CACHE_KB);
   localparam [8:0] SET_MASK = `CTM_SET_ALL >> (`CTM_SET_W - SET_BITS);

   reg [1:0] st_q;
   reg [1:0] st_d;
   reg [8:0] ic_set_q;
   reg [2:0] walk_q;
   reg [7:0] walk_address_space_id_q;
   reg [2:0] victim_q;
   reg [31:0] par_q;

   wire accept;
   wire [`CTM_TLB_N-1:0] vmatch;
   wire [`CTM_TLB_N-1:0] glob;
   wire [8*`CTM_TLB_N-1:0] address_space_id_f;
   wire [20*`CTM_TLB_N-1:0] ppn_f;
   wire [3*`CTM_TLB_N-1:0] perm_f;
   wire [31:0] rom_data;
   wire look_ns;
   wire maint_op1;

   // Decode results
   reg undef_d;
   reg [31:0] rdata_d;
   reg probe_d;
   reg cache_d;
   reg [2:0] kind_d;
   reg setway_d;
   reg icall_d;
   reg tlb_d;
   reg [1:0] tlb_op_d;
   reg par_wr_d;
   reg is_tlb_grp;

   // Lookup and kill logic
   reg [`CTM_TLB_N-1:0] kill;
   reg hit;
   reg [19:0] hit_ppn;
   reg [2:0] hit_perm;
   reg perm_ok;
   integer i, j;

   assign cp_ready = (st_q == ST_IDLE);
   assign accept = cp_valid & cp_ready;
   assign tlb_stable = (st_q == ST_IDLE);
   assign maint_op1 = (cp_op1 == `CTM_OP1_MAINT);
   assign look_ns = ~secure_state | cp_op2[`CTM_OP2_NS];

   ctm_id_rom u_rom (
      .isar_sel(cp_crm == `CTM_CRM_ISAR),
      .sel(cp_op2),
      .data(rom_data)
   );

   genvar g;
   generate
      for (g = 0; g < `CTM_TLB_N; g = g + 1) begin : g_ent
         ctm_tlb_entry u_ent (
            .clk_sys(clk_sys),
            .rst(rst),
            .fill_we(tlb_fill_valid && (victim_q == g)),
            .fill_vpn(tlb_fill_vpn),
            .fill_ppn(tlb_fill_ppn),
            .fill_address_space_id(tlb_fill_address_space_id),
            .fill_glob(tlb_fill_glob),
            .fill_ns(tlb_fill_ns),
            .fill_perm(tlb_fill_perm),
            .kill(kill[g]),
            .look_vpn(cp_wdata[31:`CTM_PAGE_LO]),
            .look_ns(look_ns),
            .vmatch(vmatch[g]),
            .glob(glob[g]),
            .address_space_id(address_space_id_f[8*g+7:8*g]),
            .ppn(ppn_f[20*g+19:20*g]),
            .perm(perm_f[3*g+2:3*g])
         );
      end
   endgenerate

   // Request decode
   always @* begin
      undef_d = 1'b0;
      rdata_d = `CTM_ZERO;
      probe_d = 1'b0;
      cache_d = 1'b0;
      kind_d = `CTM_K_NONE;
      setway_d = 1'b0;
      icall_d = 1'b0;
      tlb_d = 1'b0;
      tlb_op_d = cp_op2[1:0];
      par_wr_d = 1'b0;
      is_tlb_grp = (cp_crm == `CTM_CRM_TLB_IS) || (cp_crm == `CTM_CRM_TLB_A) ||
                   (cp_crm == `CTM_CRM_TLB_B) || (cp_crm == `CTM_CRM_TLB);
      if (maint_op1 && cp_crn == `CTM_CRN_ID) begin
         if (cp_write) begin
            undef_d = 1'b1;
         end else if (cp_crm == `CTM_CRM_FEAT || cp_crm == `CTM_CRM_ISAR) begin
            rdata_d = rom_data;
         end
      end else if (maint_op1 && cp_crn == `CTM_CRN_TLB) begin
         if (!cp_write) begin
            undef_d = 1'b1;
         end else if (!priv_mode) begin
            undef_d = 1'b1;
         end else if (is_tlb_grp && cp_op2[2] == 1'b0) begin
            tlb_d = 1'b1;
         end
         // Other encodings are ignored here
      end else if (maint_op1 && cp_crn == `CTM_CRN_CACHE) begin
         if (!cp_write) begin
            if (cp_crm == `CTM_CRM_PAR && cp_op2 == `CTM_OP2_ALL && priv_mode) begin
               rdata_d = par_q;
            end else begin
               undef_d = 1'b1;
            end
         end else if (!priv_mode) begin
            // Barriers stay legal for user code
            if (!((cp_crm == `CTM_CRM_IC && cp_op2 == `CTM_OP2_BAR) ||
                  (cp_crm == `CTM_CRM_DC_CLN && cp_op2 == `CTM_OP2_BAR) ||
                  (cp_crm == `CTM_CRM_DC_CLN && cp_op2 == `CTM_OP2_DMB))) begin
               undef_d = 1'b1;
            end
         end else begin
            case (cp_crm)
               `CTM_CRM_PAR: begin
                  par_wr_d = (cp_op2 == `CTM_OP2_ALL);
               end
               `CTM_CRM_PROBE: begin
                  if (cp_op2[`CTM_OP2_NS] && !secure_state) begin
                     undef_d = 1'b1;
                  end else begin
                     probe_d = 1'b1;
                  end
               end
               `CTM_CRM_IC_IS, `CTM_CRM_IC: begin
                  if (cp_op2 == `CTM_OP2_ALL) begin
                     icall_d = 1'b1;
                  end else if (cp_op2 == `CTM_OP2_VA && cp_crm == `CTM_CRM_IC) begin
                     cache_d = 1'b1;
                     kind_d = `CTM_K_IC_VA;
                  end else if (cp_op2 == `CTM_OP2_BP || cp_op2 == `CTM_OP2_BPVA) begin
                     cache_d = 1'b1;
                     kind_d = `CTM_K_BP;
                  end
               end
               `CTM_CRM_DC_INV, `CTM_CRM_DC_CLN, `CTM_CRM_DC_CLNU, `CTM_CRM_DC_CI: begin
                  if (cp_op2 == `CTM_OP2_VA ||
                      (cp_op2 == `CTM_OP2_SW && cp_crm != `CTM_CRM_DC_CLNU)) begin
                     cache_d = 1'b1;
                     setway_d = (cp_op2 == `CTM_OP2_SW);
                     if (cp_crm == `CTM_CRM_DC_INV) begin
                        kind_d = `CTM_K_INV;
                     end else if (cp_crm == `CTM_CRM_DC_CI) begin
                        kind_d = `CTM_K_CLNINV;
                     end else begin
                        kind_d = `CTM_K_CLEAN;
                     end
                  end
               end
               default: begin
                  cache_d = 1'b0;
               end
            endcase
         end
      end
   end

   // Probe lookup against the current space id
   always @* begin
      hit = 1'b0;
      hit_ppn = 20'h00000;
      hit_perm = 3'h0;
      for (i = 0; i < `CTM_TLB_N; i = i + 1) begin
         if (!hit && vmatch[i] && (glob[i] || address_space_id_f[8*i +: 8] == ctx_address_space_id)) begin
            hit = 1'b1;
            hit_ppn = ppn_f[20*i +: 20];
            hit_perm = perm_f[3*i +: 3];
         end
      end
      case (cp_op2[1:0])
         2'h0: perm_ok = 1'b1;
         2'h1: perm_ok = hit_perm[0];
         2'h2: perm_ok = hit_perm[1];
         2'h3: perm_ok = hit_perm[2];
         default: perm_ok = 1'b0;
      endcase
   end

   // Entry removal
   always @* begin
      kill = {`CTM_TLB_N{1'b0}};
      for (j = 0; j < `CTM_TLB_N; j = j + 1) begin
         if (st_q == ST_ADDRESS_SPACE_ID) begin
            kill[j] = (walk_q == j) && !glob[j] && (address_space_id_f[8*j +: 8] == walk_address_space_id_q);
         end else if (accept && tlb_d) begin
            case (tlb_op_d)
               2'h0: kill[j] = 1'b1;
               2'h1: kill[j] = vmatch[j] &&
                               (glob[j] || address_space_id_f[8*j +: 8] == cp_wdata[`CTM_ADDRESS_SPACE_ID_HI:0]);
               2'h3: kill[j] = vmatch[j];
               default: kill[j] = 1'b0;
            endcase
         end
      end
   end

   always @* begin
      st_d = st_q;
      case (st_q)
         ST_IDLE: begin
            if (accept && icall_d) begin
               st_d = ST_ICALL;
            end else if (accept && tlb_d && tlb_op_d == 2'h2) begin
               st_d = ST_ADDRESS_SPACE_ID;
            end
         end
         ST_ICALL: begin
            if (ic_set_q == SET_MASK) begin
               st_d = ST_IDLE;
            end
         end
         ST_ADDRESS_SPACE_ID: begin
            if (walk_q == `CTM_TLB_LAST) begin
               st_d = ST_IDLE;
            end
         end
         default: st_d = ST_IDLE;
      endcase
   end

   always @(posedge clk_sys) begin
      if (rst) begin
         st_q <= ST_IDLE;
         ic_set_q <= 9'h000;
         walk_q <= 3'h0;
         walk_address_space_id_q <= 8'h00;
         victim_q <= 3'h0;
         par_q <= `CTM_PAR_RESET;
         rsp_valid_q <= 1'b0;
         rsp_undef_q <= 1'b0;
         rsp_rdata_q <= `CTM_ZERO;
         cache_req_q <= 1'b0;
         cache_kind_q <= `CTM_K_NONE;
         cache_setway_q <= 1'b0;
         cache_way_q <= 2'h0;
         cache_set_q <= 9'h000;
         cache_line_q <= 27'h0000000;
      end else begin
         st_q <= st_d;
         // Round-robin victim keeps the fill path free of any age tracking
         if (tlb_fill_valid) begin
            victim_q <= victim_q + 3'h1;
         end
         rsp_valid_q <= accept;
         rsp_undef_q <= accept & undef_d;
         if (accept) begin
            rsp_rdata_q <= rdata_d;
         end
         if (accept && par_wr_d) begin
            par_q <= cp_wdata;
         end else if (accept && probe_d) begin
            par_q <= (hit && perm_ok) ? ({hit_ppn, cp_wdata[11:0]} & `CTM_PAR_PAGE_MASK) :
                     `CTM_PAR_FAULT;
         end
         if (accept && tlb_d) begin
            walk_q <= 3'h0;
            walk_address_space_id_q <= cp_wdata[`CTM_ADDRESS_SPACE_ID_HI:0];
         end else if (st_q == ST_ADDRESS_SPACE_ID) begin
            walk_q <= walk_q + 3'h1;
         end
         // Icache walk sweeps every set; the issuer is held off until the last one
         if (st_q == ST_ICALL) begin
            cache_req_q <= 1'b1;
            cache_kind_q <= `CTM_K_IC_ALL;
            cache_setway_q <= 1'b1;
            cache_way_q <= 2'h0;
            cache_set_q <= ic_set_q;
            ic_set_q <= ic_set_q + 9'h001;
         end else begin
            ic_set_q <= 9'h000;
            cache_req_q <= accept & cache_d;
            if (accept && cache_d) begin
               cache_kind_q <= kind_d;
               cache_setway_q <= setway_d;
               cache_way_q <= cp_wdata[`CTM_WAY_HI:`CTM_WAY_LO];
               cache_set_q <= cp_wdata[`CTM_SET_HI_MAX:`CTM_SET_LO] & SET_MASK;
               cache_line_q <= cp_wdata[31:`CTM_SET_LO];
            end
         end
      end
   end
endmodule // ctm_maint
`default_nettype wire

// file: ctm_maint_checker.sv
`timescale 1ns/10ps
`default_nettype none
module ctm_maint_checker (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic cp_valid,
   input wire logic cp_ready,
   input wire logic cp_write,
   input wire logic [3:0] cp_crn,
   input wire logic [2:0] cp_op1,
   input wire logic [3:0] cp_crm,
   input wire logic [2:0] cp_op2,
   input wire logic [31:0] cp_wdata,
   input wire logic priv_mode,
   input wire logic secure_state,
   input wire logic rsp_valid_q,
   input wire logic rsp_undef_q,
   input wire logic [31:0] rsp_rdata_q,
   input wire logic cache_req_q,
   input wire logic [2:0] cache_kind_q,
   input wire logic cache_setway_q,
   input wire logic [1:0] cache_way_q,
   input wire logic [8:0] cache_set_q,
   input wire logic [26:0] cache_line_q
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   wire logic tk = cp_valid && cp_ready && cp_op1 == 3'h0;
   wire logic rd = tk && !cp_write;
   wire logic pw = tk && cp_write && priv_mode;
   wire logic uw = tk && cp_write && !priv_mode;
   wire logic c7 = pw && cp_crn == 4'h7;
   wire logic sw = c7 && cp_op2 == 3'h2 && cp_crm inside {4'h6, 4'hA, 4'hE};
   wire logic va = c7 && cp_op2 == 3'h1 && cp_crm inside {4'h6, 4'hA, 4'hB, 4'hE};
   wire logic bid = pw && cp_crn == 4'h8 && cp_op2 == 3'h2 && cp_crm inside {4'h3, 4'h5, 4'h6, 4'h7};
   wire logic icall = c7 && cp_crm == 4'h5 && cp_op2 == 3'h0;
   // Operand is captured at the accept edge, fields are compared one cycle on
   property p_setway;
      logic [31:0] w;
      (sw, w = cp_wdata) |=> cache_req_q && cache_setway_q && cache_way_q == w[31:30] && cache_set_q == {1'b0, w[12:5]};
   endproperty
   a_setway_fields: assert property (p_setway) else $error("set/way fields wrong");
   a_va_line: assert property (va |=> cache_req_q && !cache_setway_q && cache_line_q == $past(cp_wdata) >> 5)
      else $error("line address wrong");
   a_tlb_read_undef: assert property (rd && cp_crn == 4'h8 |=> rsp_valid_q && rsp_undef_q) else $error("tlb read defined");
   a_user_tlb_undef: assert property (uw && cp_crn == 4'h8 |=> rsp_undef_q) else $error("user tlb op defined");
   a_user_cache_undef: assert property (uw && cp_crn == 4'h7 && cp_crm == 4'h6 |=> rsp_undef_q)
      else $error("user cache op defined");
   a_user_barrier_ok: assert property (uw && cp_crn == 4'h7 && cp_crm == 4'hA && cp_op2 inside {3'h4, 3'h5}
      |=> rsp_valid_q && !rsp_undef_q) else $error("user barrier refused");
   a_cache_read_undef: assert property (rd && priv_mode && cp_crn == 4'h7 && !(cp_crm == 4'h4 && cp_op2 == 3'h0)
      |=> rsp_undef_q) else $error("cache read defined");
   a_feat_rsvd_zero: assert property (rd && cp_crn == 4'h0 && cp_crm == 4'h1 && cp_op2 == 3'h3
      |=> !rsp_undef_q && rsp_rdata_q == 32'h00000000) else $error("reserved feature not zero");
   a_isar_rsvd_zero: assert property (rd && cp_crn == 4'h0 && cp_crm == 4'h2 && cp_op2 > 3'h4
      |=> rsp_rdata_q == 32'h00000000) else $error("reserved attribute not zero");
   a_ic_walk_hold: assert property (icall |=> !cp_ready ##1 (cache_req_q && cache_set_q == 9'h000)
      ##1 (!cp_ready && cache_kind_q == 3'h5) [*8]) else $error("icache walk interrupted");
   a_address_space_id_walk: assert property (bid |=> !cp_ready [*8] ##1 cp_ready) else $error("address_space_id walk length wrong");
   a_ns_probe_undef: assert property (c7 && cp_crm == 4'h8 && cp_op2[2] && !secure_state |=> rsp_undef_q)
      else $error("non-secure probe accepted");
   c_icall: cover property (icall);
   c_bid: cover property (bid);
   c_setway: cover property (sw);
endmodule // ctm_maint_checker
bind ctm_maint ctm_maint_checker ctm_maint_checker_inst (.*);
`default_nettype wire

// file: ctm_pipe_model.sv
`timescale 1ns/10ps
`default_nettype none
module ctm_pipe_model (
   input wire logic clk_sys,
   input wire logic cp_ready,
   input wire logic rsp_valid_q,
   input wire logic rsp_undef_q,
   input wire logic [31:0] rsp_rdata_q,
   output logic cp_valid,
   output logic cp_write,
   output logic [3:0] cp_crn,
   output logic [2:0] cp_op1,
   output logic [3:0] cp_crm,
   output logic [2:0] cp_op2,
   output logic [31:0] cp_wdata
);
   initial begin
      cp_valid = 1'b0;
      cp_write = 1'b0;
      cp_crn = 4'h0;
      cp_op1 = 3'h0;
      cp_crm = 4'h0;
      cp_op2 = 3'h0;
      cp_wdata = 32'h00000000;
   end
   // Any encoding the caller passes is issued, reserved reads included; the bench never writes outside the defined ones
   task automatic xfer(input logic wr, input logic [3:0] crn, input logic [3:0] crm, input logic [2:0] op2,
                       input logic [31:0] wd, output logic ok, output logic undef, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk_sys);
      cp_valid <= 1'b1;
      cp_write <= wr;
      cp_crn <= crn;
      cp_crm <= crm;
      cp_op2 <= op2;
      cp_wdata <= wd;
      do begin
         @(posedge clk_sys);
         n++;
      end while (cp_ready !== 1'b1 && n < 400);
      cp_valid <= 1'b0;
      // Released data is scrambled so a stale operand cannot pass for a real one
      cp_wdata <= ~wd;
      @(posedge clk_sys);
      ok = rsp_valid_q === 1'b1;
      undef = rsp_undef_q;
      rd = rsp_rdata_q;
   endtask
endmodule // ctm_pipe_model
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "ctm_consts.vh"
module tb_top;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic priv_mode = 1'b1;
   logic secure_state = 1'b1;
   logic [7:0] ctx_address_space_id = 8'h05;
   logic tlb_fill_valid = 1'b0;
   logic [19:0] tlb_fill_vpn = 20'h00000;
   logic [19:0] tlb_fill_ppn = 20'h00000;
   logic [7:0] tlb_fill_address_space_id = 8'h00;
   logic tlb_fill_glob = 1'b0;
   logic tlb_fill_ns = 1'b0;
   logic [2:0] tlb_fill_perm = 3'h0;
   wire logic cp_valid, cp_ready, cp_write, rsp_valid_q, rsp_undef_q, tlb_stable, cache_req_q, cache_setway_q;
   wire logic [3:0] cp_crn, cp_crm;
   wire logic [2:0] cp_op1, cp_op2, cache_kind_q;
   wire logic [31:0] cp_wdata, rsp_rdata_q;
   wire logic [1:0] cache_way_q;
   wire logic [8:0] cache_set_q;
   wire logic [26:0] cache_line_q;
   int err_total = 0;
   int checked = 0;
   int ic_n = 0;
   int i;
   logic [7:0] ic_last = 8'h00;
   logic [31:0] feat [8] = '{`CTM_PFR0, `CTM_PFR1, `CTM_DFR0, 32'h00000000, `CTM_MMFR0, `CTM_MMFR1, `CTM_MMFR2, `CTM_MMFR3};
   logic [31:0] isar [8] = '{`CTM_ISAR0, `CTM_ISAR1, `CTM_ISAR2, `CTM_ISAR3, `CTM_ISAR4, 32'h0, 32'h0, 32'h0};
   logic [3:0] cm [3] = '{4'h6, 4'hA, 4'hE};
   always #4 clk_sys = ~clk_sys;
   ctm_maint ctm_maint_inst (.clk_sys(clk_sys), .rst(rst), .cp_valid(cp_valid), .cp_ready(cp_ready),
      .cp_write(cp_write), .cp_crn(cp_crn), .cp_op1(cp_op1), .cp_crm(cp_crm), .cp_op2(cp_op2), .cp_wdata(cp_wdata),
      .priv_mode(priv_mode), .secure_state(secure_state), .ctx_address_space_id(ctx_address_space_id), .rsp_valid_q(rsp_valid_q),
      .rsp_undef_q(rsp_undef_q), .rsp_rdata_q(rsp_rdata_q), .tlb_fill_valid(tlb_fill_valid),
      .tlb_fill_vpn(tlb_fill_vpn), .tlb_fill_ppn(tlb_fill_ppn), .tlb_fill_address_space_id(tlb_fill_address_space_id),
      .tlb_fill_glob(tlb_fill_glob), .tlb_fill_ns(tlb_fill_ns), .tlb_fill_perm(tlb_fill_perm),
      .tlb_stable(tlb_stable), .cache_req_q(cache_req_q), .cache_kind_q(cache_kind_q),
      .cache_setway_q(cache_setway_q), .cache_way_q(cache_way_q), .cache_set_q(cache_set_q),
      .cache_line_q(cache_line_q));
   ctm_pipe_model ctm_pipe_model_inst (.clk_sys(clk_sys), .cp_ready(cp_ready), .rsp_valid_q(rsp_valid_q),
      .rsp_undef_q(rsp_undef_q), .rsp_rdata_q(rsp_rdata_q), .cp_valid(cp_valid), .cp_write(cp_write),
      .cp_crn(cp_crn), .cp_op1(cp_op1), .cp_crm(cp_crm), .cp_op2(cp_op2), .cp_wdata(cp_wdata));
   always @(posedge clk_sys) begin
      if (cache_req_q === 1'b1 && cache_kind_q === 3'h5) begin
         ic_n <= ic_n + 1;
         ic_last <= cache_set_q[7:0];
      end
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic wr, input logic [3:0] crn, input logic [3:0] crm, input logic [2:0] op2,
                      input logic [31:0] wd, output logic u, output logic [31:0] rd);
      logic ok;
      ctm_pipe_model_inst.xfer(wr, crn, crm, op2, wd, ok, u, rd);
      if (!ok) begin
         err_total++;
         $display("MISMATCH t=%0t request never answered", $time);
         print_verdict();
      end
   endtask
   task automatic rdc(input logic [3:0] crn, input logic [3:0] crm, input logic [2:0] op2, input logic [31:0] e,
                      input logic eu);
      logic u;
      logic [31:0] d;
      acc(1'b0, crn, crm, op2, 32'h00000000, u, d);
      chk(32'(u), 32'(eu));
      if (!eu)
         chk(d, e);
   endtask
   task automatic wrc(input logic [3:0] crn, input logic [3:0] crm, input logic [2:0] op2, input logic [31:0] wd,
                      input logic eu);
      logic u;
      logic [31:0] d;
      acc(1'b1, crn, crm, op2, wd, u, d);
      chk(32'(u), 32'(eu));
   endtask
   task automatic probe(input logic [2:0] op2, input logic [31:0] va, input logic [31:0] e);
      wrc(4'h7, 4'h8, op2, va, 1'b0);
      rdc(4'h7, 4'h4, 3'h0, e, 1'b0);
   endtask
   task automatic fill(input logic [19:0] v, input logic [19:0] p, input logic [7:0] a, input logic g,
                       input logic ns, input logic [2:0] pm);
      @(posedge clk_sys);
      tlb_fill_valid <= 1'b1;
      tlb_fill_vpn <= v;
      tlb_fill_ppn <= p;
      tlb_fill_address_space_id <= a;
      tlb_fill_glob <= g;
      tlb_fill_ns <= ns;
      tlb_fill_perm <= pm;
      @(posedge clk_sys);
      tlb_fill_valid <= 1'b0;
   endtask
   initial begin
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      rdc(4'h7, 4'h4, 3'h0, 32'h00000000, 1'b0);
      for (i = 0; i < 8; i++) rdc(4'h0, 4'h1, i[2:0], feat[i], 1'b0);
      for (i = 0; i < 8; i++) rdc(4'h0, 4'h2, i[2:0], isar[i], 1'b0);
      $display("test id registers done");
      rdc(4'h8, 4'h7, 3'h0, 32'h0, 1'b1);
      rdc(4'h7, 4'h6, 3'h1, 32'h0, 1'b1);
      priv_mode <= 1'b0;
      wrc(4'h7, 4'hA, 3'h4, 32'h0, 1'b0);
      wrc(4'h7, 4'h6, 3'h1, 32'h0, 1'b1);
      wrc(4'h8, 4'h7, 3'h0, 32'h0, 1'b1);
      wrc(4'h7, 4'h8, 3'h0, 32'h0, 1'b1);
      priv_mode <= 1'b1;
      $display("test access faults done");
      for (i = 0; i < 3; i++) begin
         wrc(4'h7, cm[i], 3'h2, 32'h9FFFF57F, 1'b0);
         chk(32'({cache_req_q, cache_setway_q, cache_way_q, cache_set_q}), 32'h00001CAB);
         chk(32'(cache_kind_q), i + 1);
      end
      wrc(4'h7, 4'hE, 3'h1, 32'hDEADBEEF, 1'b0);
      chk(32'(cache_line_q), 32'hDEADBEEF >> 5);
      wrc(4'h7, 4'h5, 3'h0, 32'h0, 1'b0);
      rdc(4'h0, 4'h1, 3'h0, `CTM_PFR0, 1'b0);
      repeat (2) @(posedge clk_sys);
      chk(ic_n, 256);
      chk(32'(ic_last), 32'h000000FF);
      chk(32'(tlb_stable), 32'h00000001);
      $display("test cache operations done");
      fill(20'h12345, 20'hABCDE, 8'h05, 1'b0, 1'b0, 3'h7);
      fill(20'h22222, 20'h33333, 8'h05, 1'b0, 1'b1, 3'h7);
      fill(20'h44444, 20'h55555, 8'h07, 1'b1, 1'b0, 3'h0);
      fill(20'h66666, 20'h77777, 8'h09, 1'b0, 1'b0, 3'h7);
      probe(3'h0, 32'h12345ABC, 32'hABCDE000);
      probe(3'h4, 32'h22222000, 32'h33333000);
      for (i = 0; i < 4; i++) probe(i[2:0], 32'h44444000, i == 0 ? 32'h55555000 : 32'h1);
      secure_state <= 1'b0;
      wrc(4'h7, 4'h8, 3'h4, 32'h22222000, 1'b1);
      secure_state <= 1'b1;
      ctx_address_space_id <= 8'h06;
      probe(3'h0, 32'h12345000, 32'h1);
      wrc(4'h8, 4'h3, 3'h1, 32'h12345006, 1'b0);
      ctx_address_space_id <= 8'h05;
      probe(3'h0, 32'h12345000, 32'hABCDE000);
      wrc(4'h8, 4'h3, 3'h1, 32'h12345005, 1'b0);
      probe(3'h0, 32'h12345000, 32'h1);
      ctx_address_space_id <= 8'h09;
      probe(3'h0, 32'h66666000, 32'h77777000);
      wrc(4'h8, 4'h7, 3'h2, 32'h00000009, 1'b0);
      chk(32'(tlb_stable), 32'h00000000);
      probe(3'h0, 32'h66666000, 32'h1);
      probe(3'h0, 32'h44444000, 32'h55555000);
      wrc(4'h8, 4'h5, 3'h3, 32'h444440FF, 1'b0);
      probe(3'h0, 32'h44444000, 32'h1);
      ctx_address_space_id <= 8'h05;
      probe(3'h4, 32'h22222000, 32'h33333000);
      wrc(4'h8, 4'h6, 3'h0, 32'hFFFFFFFF, 1'b0);
      probe(3'h4, 32'h22222000, 32'h1);
      $display("test tlb maintenance done");
      print_verdict();
   end
endmodule // tb_top
`default_nettype wire
